// File: inc/dpl_pkg.sv
// Constants and types for the DPLL phase detector, offset and lock stage.
// Assumes a single 125 MHz system clock and a byte-wide register port.
package dpl_pkg;

	// ---------------------------------------------------------------
	// Register byte addresses
	// ---------------------------------------------------------------
	localparam logic [15:0] ADDR_FIXED_OFF   = 16'h030f; // Five bytes, LSB first
	localparam logic [15:0] ADDR_STEP_SIZE   = 16'h0314; // Two bytes, LSB first
	localparam logic [15:0] ADDR_SLEW_LIMIT  = 16'h0316; // Two bytes, LSB first
	localparam logic [15:0] ADDR_STEP_CTRL   = 16'h0a0c;
	localparam int          REG_BYTES        = 9;        // 0x030f..0x0317 in one run

	// Step control bit positions
	localparam int CTRL_INC_BIT = 0;
	localparam int CTRL_DEC_BIT = 1;
	localparam int CTRL_CLR_BIT = 2;

	// Reset values
	localparam logic [7:0]  REG_BYTE_RST = 8'h00;
	localparam logic [39:0] OFF_RST      = 40'h00_0000_0000;

	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int TW = 40;  // Timestamp and offset width, ps
	localparam int FW = 48;  // Loop filter internal width

	// ---------------------------------------------------------------
	// Lock detector tub levels
	// ---------------------------------------------------------------
	localparam logic signed [12:0] LVL_EMPTY = 13'h1800; // -2048
	localparam logic signed [12:0] LVL_FULL  = 13'h0800; // +2048
	localparam logic signed [12:0] LVL_LOW   = 13'h1c00; // -1024
	localparam logic signed [12:0] LVL_HIGH  = 13'h0400; // +1024

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ        = 125;
	localparam int SLEW_TICK_US   = 1000;                    // Slew update every 1 ms
	localparam int SLEW_TICK_CYC  = SLEW_TICK_US * CLK_MHZ;  // ns/s limit equals ps per ms

	// Loop operating mode
	typedef enum logic [1:0] {
		MODE_FREERUN,
		MODE_CLOSED,
		MODE_HOLDOVER
	} dpl_mode_e;

endpackage : dpl_pkg

// File: rtl/dpl_lock_detect.sv
// Fill/drain tub lock detector with hysteresis marks.
// Assumes the caller supplies an error magnitude and threshold of equal width.
`timescale 1ns/1ps
module dpl_lock_detect #(
	parameter int MW = 40
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          sampleEn,
	input  wire logic          hold,
	input  wire logic          forceEmpty,
	input  wire logic [MW-1:0] errMag,
	input  wire logic [MW-1:0] thresh,
	input  wire logic [7:0]    fillStep,
	input  wire logic [7:0]    drainStep,
	output logic               locked
);
	import dpl_pkg::*;

	logic signed [12:0] level_r;
	logic signed [13:0] levelSum;
	logic signed [12:0] level_nxt;

	// ---------------------------------------------------------------
	// Level update
	// ---------------------------------------------------------------
	// Fill or drain, never both; sign of error already stripped
	always_comb begin
		if (errMag <= thresh) begin
			levelSum = 14'(level_r) + $signed({6'h00, fillStep});
		end else begin
			levelSum = 14'(level_r) - $signed({6'h00, drainStep});
		end
		// Clamp so the tub can never wrap around
		if (levelSum > 14'(LVL_FULL)) begin
			level_nxt = LVL_FULL;
		end else if (levelSum < 14'(LVL_EMPTY)) begin
			level_nxt = LVL_EMPTY;
		end else begin
			level_nxt = levelSum[12:0];
		end
	end

	// Tub state; empty on reset or forced empty
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			level_r <= LVL_EMPTY;
		end else if (forceEmpty) begin
			level_r <= LVL_EMPTY;
		end else if (sampleEn && !hold) begin
			level_r <= level_nxt;
		end
	end

	// Hysteresis: apart from forceEmpty, only crossing a mark changes the indication
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			locked <= 1'b0;
		end else if (forceEmpty) begin
			locked <= 1'b0;
		end else if (sampleEn && !hold) begin
			if (level_nxt < LVL_LOW) begin
				locked <= 1'b0;
			end else if (level_nxt > LVL_HIGH) begin
				locked <= 1'b1;
			end
		end
	end

endmodule : dpl_lock_detect

// File: rtl/dpl_phase_detect.sv
// DPLL phase/frequency detector, closed-loop offset, loop filter and lock detectors.
// Assumes timestamps arrive as paired strobes on the system clock and the
// register port is a byte-wide write/read strobe interface.
// Functional notes
// - Integrate reference minus feedback phase error
// - Fixed 40-bit signed offset in ps
// - Unsigned 16-bit step size at 0x0314
// - Bit 0 write adds step size
// - Bit 1 write subtracts step size
// - Increment and decrement bits self-clear
// - Bit 2 write zeroes incremental offset
// - Pins can trigger increment, decrement, clear
// - Incremental and fixed offsets combine independently
// - Offset steps pass through slew limiter
// - Third-order IIR filter, four coefficients
// - Coefficient is fraction times two^-exponent
// - Alpha also scaled by two positive powers
// - Saturating tub from -2048 to +2048
// - Unlock below -1024, lock above +1024
// - Separate 8-bit fill and drain steps
// - Fill within threshold, else drain, sign ignored
// - Phase threshold 16-bit unsigned ps
// - Free-run or holdover reports unlocked
// - Lock state held during switchover in closed loop
// - Frequency detector uses period difference magnitude
// - Frequency threshold 24-bit unsigned ps
// - 16-bit slew limit, zero disables
`timescale 1ns/1ps
module dpl_phase_detect #(
	parameter int SLEW_TICK = dpl_pkg::SLEW_TICK_CYC
) (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	// Register port
	input  wire logic                    regWrEn,
	input  wire logic                    regRdEn,
	input  wire logic [15:0]             regAddr,
	input  wire logic [7:0]              regWrData,
	output logic      [7:0]              regRdData,
	// Multifunction pin triggers
	input  wire logic                    pinInc,
	input  wire logic                    pinDec,
	input  wire logic                    pinClr,
	// Edge timestamps
	input  wire logic                    sampleValid,
	input  wire logic [dpl_pkg::TW-1:0]  refTime,
	input  wire logic [dpl_pkg::TW-1:0]  fbTime,
	// Loop state
	input  wire dpl_pkg::dpl_mode_e      loopMode,
	input  wire logic                    switchover,
	// Profile values
	input  wire logic [15:0]             phaseThresh,
	input  wire logic [23:0]             freqThresh,
	input  wire logic [7:0]              phaseFill,
	input  wire logic [7:0]              phaseDrain,
	input  wire logic [7:0]              freqFill,
	input  wire logic [7:0]              freqDrain,
	input  wire logic [15:0]             alphaFrac,
	input  wire logic [4:0]              alphaExp,
	input  wire logic [2:0]              alphaPow0,
	input  wire logic [2:0]              alphaPow1,
	input  wire logic [15:0]             betaFrac,
	input  wire logic [4:0]              betaExp,
	input  wire logic [15:0]             gammaFrac,
	input  wire logic [4:0]              gammaExp,
	input  wire logic [15:0]             deltaFrac,
	input  wire logic [4:0]              deltaExp,
	// Results
	output logic signed [dpl_pkg::TW-1:0] phaseErr,
	output logic signed [dpl_pkg::FW-1:0] tuneCorr,
	output logic signed [dpl_pkg::TW-1:0] appliedOffset,
	output logic                          phaseLocked,
	output logic                          freqLocked
);
	import dpl_pkg::*;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Apply fraction in [0,1) and a negative power of two
	function automatic logic signed [FW-1:0] coefApply(
		input logic signed [FW-1:0] x,
		input logic [15:0]          frac,
		input logic [4:0]           sh
	);
		logic signed [FW+16:0] prod;
		prod      = x * $signed({1'b0, frac});
		coefApply = FW'(prod >>> (16 + sh));
	endfunction : coefApply

	// Magnitude of a signed word; sign does not matter to detectors
	function automatic logic [TW-1:0] absVal(input logic signed [TW-1:0] v);
		absVal = v[TW-1] ? TW'(-v) : v;
	endfunction : absVal

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	logic [7:0]    regByte_r [REG_BYTES];
	logic [15:0]   regIdx;
	logic          inRun;
	logic          ctrlWr;
	logic          incReq;
	logic          decReq;
	logic          clrReq;

	assign regIdx = regAddr - ADDR_FIXED_OFF;
	assign inRun  = (regAddr >= ADDR_FIXED_OFF) && (regIdx < 16'(REG_BYTES));
	assign ctrlWr = regWrEn && (regAddr == ADDR_STEP_CTRL);

	// Plain storage bytes for offset, step size and slew limit
	generate
		for (genvar i = 0; i < REG_BYTES; i++) begin : g_byte
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					regByte_r[i] <= REG_BYTE_RST;
				end else if (regWrEn && inRun && regIdx == 16'(i)) begin
					regByte_r[i] <= regWrData;
				end
			end
		end
	endgenerate

	logic signed [TW-1:0] fixedOff;
	logic [15:0]          stepSize;
	logic [15:0]          slewLimit;

	assign fixedOff  = {regByte_r[4], regByte_r[3], regByte_r[2], regByte_r[1], regByte_r[0]};
	assign stepSize  = {regByte_r[6], regByte_r[5]};
	assign slewLimit = {regByte_r[8], regByte_r[7]};

	// Control bits are strobes, never stored, so they read back as zero
	assign incReq = (ctrlWr && regWrData[CTRL_INC_BIT]) || pinInc;
	assign decReq = (ctrlWr && regWrData[CTRL_DEC_BIT]) || pinDec;
	assign clrReq = (ctrlWr && regWrData[CTRL_CLR_BIT]) || pinClr;

	// Registered read; unmapped and control addresses return zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			regRdData <= inRun ? regByte_r[regIdx[3:0]] : 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// Incremental offset accumulator
	// ---------------------------------------------------------------
	logic signed [TW-1:0] incOff_r;

	// Clear wins over a simultaneous step; inc and dec together cancel
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			incOff_r <= OFF_RST;
		end else if (clrReq) begin
			incOff_r <= OFF_RST;
		end else if (incReq && !decReq) begin
			incOff_r <= incOff_r + TW'(stepSize);
		end else if (decReq && !incReq) begin
			incOff_r <= incOff_r - TW'(stepSize);
		end
	end

	// ---------------------------------------------------------------
	// Slew limiter
	// ---------------------------------------------------------------
	logic signed [TW-1:0] targetOff;
	logic signed [TW-1:0] offDiff;
	logic signed [TW-1:0] slewStep;
	logic [31:0]          tickCnt_r;
	logic                 slewTick;

	// Fixed and incremental parts are kept apart and only summed here
	assign targetOff = fixedOff + incOff_r;
	assign offDiff   = targetOff - appliedOffset;
	assign slewStep  = TW'(slewLimit);
	assign slewTick  = (tickCnt_r == 32'(SLEW_TICK - 1));

	// Millisecond enable: a limit in ns/s is then a step in ps per tick
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tickCnt_r <= 32'h0000_0000;
		end else if (slewTick) begin
			tickCnt_r <= 32'h0000_0000;
		end else begin
			tickCnt_r <= tickCnt_r + 32'h0000_0001;
		end
	end

	// Offset seen by the detector walks toward the target
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			appliedOffset <= OFF_RST;
		end else if (slewLimit == 16'h0000) begin
			appliedOffset <= targetOff;
		end else if (slewTick) begin
			if (offDiff > slewStep) begin
				appliedOffset <= appliedOffset + slewStep;
			end else if (offDiff < -slewStep) begin
				appliedOffset <= appliedOffset - slewStep;
			end else begin
				appliedOffset <= targetOff;
			end
		end
	end

	// ---------------------------------------------------------------
	// Phase and period detector
	// ---------------------------------------------------------------
	logic signed [TW-1:0] phaseRaw;
	logic signed [TW-1:0] periodDiff;
	logic [TW-1:0]        refPrev_r;
	logic [TW-1:0]        fbPrev_r;
	logic                 havePrev_r;
	logic                 phaseValid_r;
	logic                 freqValid_r;
	logic signed [TW-1:0] periodDiff_r;
	logic                 closedLoop;

	assign closedLoop = (loopMode == MODE_CLOSED);
	// Offset shifts where the feedback edge is expected to sit
	assign phaseRaw   = $signed(refTime - fbTime) - appliedOffset;
	assign periodDiff = $signed((refTime - refPrev_r) - (fbTime - fbPrev_r));

	// Previous edges, needed before any period can be formed
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			refPrev_r  <= OFF_RST;
			fbPrev_r   <= OFF_RST;
			havePrev_r <= 1'b0;
		end else if (!closedLoop) begin
			havePrev_r <= 1'b0;
		end else if (sampleValid) begin
			refPrev_r  <= refTime;
			fbPrev_r   <= fbTime;
			havePrev_r <= 1'b1;
		end
	end

	// Sample registers feeding the filter and the detectors
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phaseErr     <= OFF_RST;
			periodDiff_r <= OFF_RST;
			phaseValid_r <= 1'b0;
			freqValid_r  <= 1'b0;
		end else begin
			phaseValid_r <= sampleValid && closedLoop;
			freqValid_r  <= sampleValid && closedLoop && havePrev_r;
			if (sampleValid && closedLoop) begin
				phaseErr     <= phaseRaw;
				periodDiff_r <= periodDiff;
			end
		end
	end

	// ---------------------------------------------------------------
	// Third-order IIR loop filter
	// ---------------------------------------------------------------
	logic signed [FW-1:0] errWide;
	logic signed [FW-1:0] propTerm;
	logic signed [FW-1:0] intAcc_r;
	logic signed [FW-1:0] stage0;
	logic signed [FW-1:0] pole1_r;
	logic signed [FW-1:0] pole2_r;
	logic [3:0]           alphaGain;

	assign errWide   = FW'(phaseErr);
	assign alphaGain = 4'(alphaPow0) + 4'(alphaPow1);
	// Alpha split in two shifts for dynamic range above unity
	assign propTerm  = FW'(coefApply(errWide, alphaFrac, alphaExp) <<< alphaGain);
	assign stage0    = propTerm + intAcc_r;

	// Digital code pump: beta path integrates every error sample
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			intAcc_r <= '0;
		end else if (phaseValid_r) begin
			intAcc_r <= intAcc_r + coefApply(errWide, betaFrac, betaExp);
		end
	end

	// Two smoothing poles; state frozen outside closed loop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pole1_r <= '0;
			pole2_r <= '0;
		end else if (phaseValid_r) begin
			pole1_r <= pole1_r + coefApply(stage0 - pole1_r, gammaFrac, gammaExp);
			pole2_r <= pole2_r + coefApply(pole1_r - pole2_r, deltaFrac, deltaExp);
		end
	end

	// Correction word toward the synthesizer tuning input
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tuneCorr <= '0;
		end else if (phaseValid_r) begin
			tuneCorr <= pole2_r;
		end
	end

	// ---------------------------------------------------------------
	// Lock detectors
	// ---------------------------------------------------------------
	logic forceEmpty;

	// Free-run and holdover empty both tubs at once
	assign forceEmpty = (loopMode == MODE_FREERUN) || (loopMode == MODE_HOLDOVER);

	dpl_lock_detect #(
		.MW(TW)
	) u_phaseLock (
		.clk       (clk),
		.rstn      (rstn),
		.sampleEn  (phaseValid_r),
		.hold      (switchover),
		.forceEmpty(forceEmpty),
		.errMag    (absVal(phaseErr)),
		.thresh    (TW'(phaseThresh)),
		.fillStep  (phaseFill),
		.drainStep (phaseDrain),
		.locked    (phaseLocked)
	);

	dpl_lock_detect #(
		.MW(TW)
	) u_freqLock (
		.clk       (clk),
		.rstn      (rstn),
		.sampleEn  (freqValid_r),
		.hold      (switchover),
		.forceEmpty(forceEmpty),
		.errMag    (absVal(periodDiff_r)),
		.thresh    (TW'(freqThresh)),
		.fillStep  (freqFill),
		.drainStep (freqDrain),
		.locked    (freqLocked)
	);

endmodule : dpl_phase_detect

// File: sim/dpl_phase_detect_chk.sv
// Port-level checks for the phase detector, offset and lock stage.
// Assumes binding to dpl_phase_detect, one clock domain, async active-low reset.
`timescale 1ns/1ps
module dpl_phase_detect_chk
	import dpl_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rstn,
	input wire logic                  regRdEn,
	input wire logic [15:0]           regAddr,
	input wire logic [7:0]            regRdData,
	input wire logic                  sampleValid,
	input wire logic [TW-1:0]         refTime,
	input wire logic [TW-1:0]         fbTime,
	input wire dpl_mode_e             loopMode,
	input wire logic                  switchover,
	input wire logic signed [TW-1:0]  phaseErr,
	input wire logic signed [TW-1:0]  appliedOffset,
	input wire logic                  phaseLocked,
	input wire logic                  freqLocked
);
	// ---------------------------------------------
	// Sequences and properties
	// ---------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// A timestamp pair the loop accepts
	sequence s_accept;
		sampleValid && loopMode == MODE_CLOSED;
	endsequence
	// Switchover held long enough to cover the lock pipeline
	sequence s_frozen;
		switchover [*3];
	endsequence

	property p_ctrl_rd;
		regRdEn && (regAddr == ADDR_STEP_CTRL || regAddr == 16'h0000) |=> regRdData == 8'h00;
	endproperty
	property p_rd_stands;
		!regRdEn |=> $stable(regRdData);
	endproperty
	property p_err_calc;
		s_accept |=> phaseErr == $past(refTime) - $past(fbTime) - $past(appliedOffset);
	endproperty
	property p_err_stands;
		!(sampleValid && loopMode == MODE_CLOSED) |=> $stable(phaseErr);
	endproperty
	property p_plock_rise;
		$rose(phaseLocked) |-> $past(sampleValid, 2) && $past(loopMode, 2) == MODE_CLOSED;
	endproperty
	property p_plock_fall;
		$fell(phaseLocked) |-> $past(sampleValid, 2) || $past(loopMode) != MODE_CLOSED;
	endproperty
	property p_flock_rise;
		$rose(freqLocked) |-> $past(sampleValid, 2) && $past(loopMode, 2) == MODE_CLOSED;
	endproperty
	property p_sw_hold;
		s_frozen |=> $stable(phaseLocked) && $stable(freqLocked);
	endproperty
	property p_open_unlock;
		loopMode != MODE_CLOSED && !switchover |=> !phaseLocked && !freqLocked;
	endproperty

	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control or unmapped read not zero");
	a_rd_stands: assert property (p_rd_stands) else $error("read data moved without read");
	a_err_calc: assert property (p_err_calc) else $error("phase error value wrong");
	a_err_stands: assert property (p_err_stands) else $error("phase error moved without sample");
	a_plock_rise: assert property (p_plock_rise) else $error("phase lock rose without sample");
	a_plock_fall: assert property (p_plock_fall) else $error("phase lock fell without cause");
	a_flock_rise: assert property (p_flock_rise) else $error("freq lock rose without sample");
	a_sw_hold: assert property (p_sw_hold) else $error("lock changed during switchover");
	a_open_unlock: assert property (p_open_unlock) else $error("locked outside closed loop");
endmodule : dpl_phase_detect_chk

// File: sim/dpl_stamp_source.sv
// Reference and feedback edge timestamp source for the phase detector.
// Assumes the bench raises fire one cycle per wanted sample.
`timescale 1ns/1ps
module dpl_stamp_source
	import dpl_pkg::*;
#(
	parameter logic [TW-1:0] REF_PERIOD = 40'h00_0000_1f40 // Edge spacing, ps
) (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 fire,
	input  wire logic signed [TW-1:0] skew,
	output logic                      sampleValid,
	output logic [TW-1:0]             refTime,
	output logic [TW-1:0]             fbTime
);
	logic [TW-1:0] refAcc_r;

	// Equal periods on both sides; skew sets feedback lag
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			refAcc_r <= '0;
			sampleValid <= 1'b0;
			refTime <= '0;
			fbTime <= '0;
		end else if (fire) begin
			refAcc_r <= refAcc_r + REF_PERIOD;
			sampleValid <= 1'b1;
			refTime <= refAcc_r + REF_PERIOD;
			fbTime <= refAcc_r + REF_PERIOD - skew;
		end else begin
			sampleValid <= 1'b0;
			refTime <= ~refTime; // Stale stamps must not look valid
			fbTime <= ~fbTime;
		end
	end
endmodule : dpl_stamp_source

// File: sim/dpl_phase_detect_bench.sv
// Self-checking bench for the phase detector, offset and lock stage.
// Assumes the checker and the stamp source are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module dpl_phase_detect_bench;
	import dpl_pkg::*;
	logic                 clk = 0, rstn = 0, regWrEn = 0, regRdEn = 0, fire = 0, switchover = 0;
	logic                 pinInc = 0, pinDec = 0, pinClr = 0, sampleValid, phaseLocked, freqLocked;
	logic [15:0]          regAddr = '0, phaseThresh = 16'h000a, alphaFrac = '0, betaFrac = '0;
	logic [15:0]          gammaFrac = '0, deltaFrac = '0;
	logic [7:0]           regWrData = '0, regRdData, phaseFill = 8'hff, phaseDrain = 8'hc0;
	logic [7:0]           freqFill = 8'hff, freqDrain = 8'hc0;
	logic [23:0]          freqThresh = 24'h0003e8;
	logic [4:0]           alphaExp = '0, betaExp = 5'h04, gammaExp = '0, deltaExp = '0;
	logic [2:0]           alphaPow0 = 3'h1, alphaPow1 = '0;
	logic signed [TW-1:0] skew = '0, phaseErr, appliedOffset;
	logic [TW-1:0]        refTime, fbTime;
	logic signed [FW-1:0] tuneCorr;
	dpl_mode_e            loopMode = MODE_FREERUN;
	int                   fails = 0, compares = 0;

	// Short slew tick keeps slewed moves within a few hundred cycles
	dpl_phase_detect #(.SLEW_TICK(10)) u_dpl_phase_detect(.clk, .rstn, .regWrEn, .regRdEn, .regAddr,
		.regWrData, .regRdData, .pinInc, .pinDec, .pinClr, .sampleValid, .refTime, .fbTime, .loopMode,
		.switchover, .phaseThresh, .freqThresh, .phaseFill, .phaseDrain, .freqFill, .freqDrain,
		.alphaFrac, .alphaExp, .alphaPow0, .alphaPow1, .betaFrac, .betaExp, .gammaFrac, .gammaExp,
		.deltaFrac, .deltaExp, .phaseErr, .tuneCorr, .appliedOffset, .phaseLocked, .freqLocked);
	dpl_stamp_source u_dpl_stamp_source(.clk, .rstn, .fire, .skew, .sampleValid, .refTime, .fbTime);

	always #4 clk = ~clk;

	// ---------------------------------------------
	// Bus and sample helpers
	// ---------------------------------------------
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		regWrEn = 1;
		regAddr = a;
		regWrData = d;
		@(negedge clk);
		regWrEn = 0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk);
		regRdEn = 1;
		regAddr = a;
		@(negedge clk);
		regRdEn = 0;
		`CHK("regRdData", e, regRdData)
	endtask : rd
	task automatic fix(input logic [39:0] v);
		for (int i = 0; i < 5; i++) wr(ADDR_FIXED_OFF + 16'(i), v[8*i +: 8]);
	endtask : fix
	task automatic offChk(input logic signed [TW-1:0] e);
		repeat (3) @(negedge clk);
		`CHK("appliedOffset", e, appliedOffset)
	endtask : offChk
	// Each sample waits out the whole lock pipeline
	task automatic smp(input logic signed [TW-1:0] s, input int n);
		repeat (n) begin
			@(negedge clk);
			fire = 1;
			skew = s;
			@(negedge clk);
			fire = 0;
			repeat (4) @(negedge clk);
		end
	endtask : smp
	task automatic pulse(input int w);
		@(negedge clk);
		{pinClr, pinDec, pinInc} = 3'(w);
		@(negedge clk);
		{pinClr, pinDec, pinInc} = 3'h0;
	endtask : pulse

	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	task automatic t_regs;
		rd(ADDR_SLEW_LIMIT, 8'h00);
		wr(ADDR_STEP_SIZE, 8'h64);
		wr(ADDR_STEP_SIZE + 16'h0001, 8'h00);
		rd(ADDR_STEP_SIZE, 8'h64);
		rd(ADDR_STEP_SIZE + 16'h0001, 8'h00);
		wr(ADDR_FIXED_OFF + 16'h0004, 8'h80);
		rd(ADDR_FIXED_OFF + 16'h0004, 8'h80);
		wr(ADDR_FIXED_OFF + 16'h0004, 8'h00);
		rd(16'h0000, 8'h00);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_offset;
		wr(ADDR_STEP_CTRL, 8'h01);
		wr(ADDR_STEP_CTRL, 8'h01);
		offChk(200);
		rd(ADDR_STEP_CTRL, 8'h00);
		wr(ADDR_STEP_CTRL, 8'h02);
		offChk(100);
		wr(ADDR_STEP_CTRL, 8'h03);
		offChk(100);
		pulse(1);
		offChk(200);
		pulse(2);
		offChk(100);
		fix(40'hff_ffff_ffce);
		offChk(50);
		pulse(4);
		offChk(-50);
		wr(ADDR_STEP_CTRL, 8'h01);
		wr(ADDR_STEP_CTRL, 8'h05);
		offChk(-50);
		fix(40'h0);
		offChk(0);
		$display("t_offset done");
	endtask : t_offset
	task automatic t_lock;
		@(negedge clk);
		loopMode = MODE_CLOSED;
		smp(-40'sd10, 12);
		`CHK("phaseErr", -40'sd10, phaseErr)
		`CHK("phaseLocked", 1'b0, phaseLocked)
		smp(-40'sd10, 1);
		`CHK("phaseLocked", 1'b1, phaseLocked)
		`CHK("freqLocked", 1'b0, freqLocked)
		smp(-40'sd10, 1);
		`CHK("freqLocked", 1'b1, freqLocked)
		smp(-40'sd10, 10);
		smp(40'sd500, 16);
		`CHK("phaseLocked", 1'b1, phaseLocked)
		smp(40'sd500, 1);
		`CHK("phaseLocked", 1'b0, phaseLocked)
		$display("t_lock done");
	endtask : t_lock
	task automatic t_hold;
		smp(-40'sd10, 13);
		`CHK("phaseLocked", 1'b1, phaseLocked)
		switchover = 1;
		smp(40'sd500, 20);
		`CHK("phaseLocked", 1'b1, phaseLocked)
		switchover = 0;
		loopMode = MODE_HOLDOVER;
		repeat (2) @(negedge clk);
		`CHK("phaseLocked", 1'b0, phaseLocked)
		`CHK("freqLocked", 1'b0, freqLocked)
		smp(40'sd77, 1);
		`CHK("phaseErr", 40'sd500, phaseErr)
		loopMode = MODE_CLOSED;
		smp(-40'sd10, 12);
		`CHK("phaseLocked", 1'b0, phaseLocked)
		smp(-40'sd10, 1);
		`CHK("phaseLocked", 1'b1, phaseLocked)
		$display("t_hold done");
	endtask : t_hold
	task automatic t_filter;
		alphaFrac = 16'h8000;
		alphaPow1 = 3'h1;
		betaFrac = 16'h1000;
		gammaFrac = 16'h8000;
		deltaFrac = 16'h8000;
		// Alpha 0.5 * 2^(1+1) on 1000 ps gives 2000; halved twice by the poles, two samples late
		smp(40'sd1000, 3);
		`CHK("tuneCorr", 48'sd500, tuneCorr)
		smp(40'sd1000, 5);
		`CHK("tuneCorr positive", 1'b1, tuneCorr > 0)
		$display("t_filter done");
	endtask : t_filter
	task automatic t_slew;
		wr(ADDR_SLEW_LIMIT, 8'h05);
		wr(ADDR_STEP_CTRL, 8'h01);
		repeat (15) @(negedge clk);
		`CHK("appliedOffset slewing", 1'b1, appliedOffset > 0 && appliedOffset <= 10)
		repeat (300) @(negedge clk);
		`CHK("appliedOffset", 40'sd100, appliedOffset)
		$display("t_slew done");
	endtask : t_slew

	task automatic results;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// Main sequence after six reset cycles
	initial begin
		repeat (6) @(negedge clk);
		rstn = 1;
		t_regs();
		t_offset();
		t_lock();
		t_hold();
		t_filter();
		t_slew();
		results();
	end
	// Watchdog well beyond the expected run of about 1000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		results();
	end
endmodule : dpl_phase_detect_bench

bind dpl_phase_detect dpl_phase_detect_chk u_dpl_phase_detect_chk(.clk, .rstn, .regRdEn, .regAddr, .regRdData,
	.sampleValid, .refTime, .fbTime, .loopMode, .switchover, .phaseErr, .appliedOffset, .phaseLocked, .freqLocked);
